// *** src/pwr_cc_map.svh ***
`ifndef PWR_CC_MAP_SVH
`define PWR_CC_MAP_SVH
`define FAULT_CONTROL_ADDR      8'h1B
`define POWER_CONTROL_ADDR      8'h1C
`define CONNECTION_STATUS_ADDR  8'h1D
`define FAULT_CONTROL_RESET     8'h00
`define POWER_CONTROL_RESET     8'h60
`define CONNECTION_STATUS_RESET 8'h00
`define FAULT_CONTROL_MASK      8'h09
`define POWER_CONTROL_MASK      8'h7F
`define FC_TIMER_OFF_BIT        3
`define FC_OCP_OFF_BIT          0
`define PC_MON_OFF_BIT          6
`define PC_ALARM_OFF_BIT        5
`define PC_AUTO_DISCHARGE_ON_DISCONNECT_BIT       4
`define PC_BLEED_BIT            3
`define PC_FORCED_DISCHARGE_BIT      2
`define PC_CAP_BIT              1
`define PC_CABLE_PWR_BIT        0
`define CS_SEARCH_BIT           5
`define CS_ROLE_BIT             4
`define DISCH_TIMEOUT_MS        650
`define CLK_MHZ                 125
`define DISCH_TIMEOUT_CYC       (`DISCH_TIMEOUT_MS * 1000 * `CLK_MHZ)
`endif

// *** src/pwr_cc_pkg.sv ***
package pwr_cc_pkg;
    typedef enum logic [1:0] {
        TERM_RA   = 2'h0,
        TERM_PULLUP = 2'h1,
        TERM_PULLDN = 2'h2,
        TERM_OPEN = 2'h3
    } term_e;
    typedef enum logic [1:0] {
        DS_IDLE   = 2'h0,
        DS_STOP   = 2'h1,
        DS_ACTIVE = 2'h2
    } disch_e;
endpackage

// *** src/pin_status_if.sv ***
`timescale 1ns/1ps
interface pin_status_if;
    logic [1:0] term;
    logic [1:0] sense;
    logic       role;
    logic       blank;
    logic [1:0] status;
    modport calc (input term, input sense, input role, input blank, output status);
    modport user (output term, output sense, output role, output blank, input status);
endinterface

// *** src/pin_status_calc.sv ***
`timescale 1ns/1ps
module pin_status_calc
    import pwr_cc_pkg::*;
(
    pin_status_if.calc p // One pin's status path
);
    // Sense code is already in the role's encoding; only masking happens here
    always_comb begin
        // RULE17 - Ra open forced zero
        if (p.blank || p.term == TERM_RA || p.term == TERM_OPEN) begin
            p.status = 2'h0;
        // RULE15 - pull-up reserved code
        end else if ((p.term == TERM_PULLUP || !p.role) && p.sense == 2'h3) begin
            p.status = 2'h0;
        end else begin
            // RULE16 - sink advertisement code
            p.status = p.sense;
        end
    end
endmodule

// *** src/power_fault_cc_status_regs.sv ***
// Functional notes
// RULE1 - Timer off bit stops discharge supervision
// RULE2 - Bit0 disables cable-power overcurrent protection
// RULE3 - Monitor off zeroes bus voltage results
// RULE4 - Alarm off bit suppresses voltage alarms
// RULE5 - Source disconnect: stop sourcing, then discharge
// RULE6 - Sink disconnect: discharge only
// RULE7 - Sourcing never outlasts discharge start
// RULE8 - Discharge ends below safe zero volts
// RULE9 - Bleed bit drives low-current load
// RULE10 - Forced bit discharges regardless of connection
// RULE11 - Capability bit stored, no function
// RULE12 - Bit0 enables cable power, reset off
// RULE13 - Searching bit high while toggling
// RULE14 - Resolved role: 0 pull-up, 1 pull-down
// RULE15 - Pull-up side codes open/Ra/Rd/reserved
// RULE16 - Pull-down side codes current advertisement
// RULE17 - Ra or open termination reads zero
// RULE18 - Searching or flipped cable power reads zero; code blanks both pins when cable power is on with orientation bit low
// RULE19 - Status change raises host alert
// RULE20 - Orientation steers cable power pin
// RULE21 - Termination encoding Ra/up/down/open
// RULE22 - Flag failure when discharge times out
// RULE23 - Reserved bits zero; status writes ignored
`timescale 1ns/1ps
`include "pwr_cc_map.svh"
module power_fault_cc_status_regs
    import pwr_cc_pkg::*;
#(
    parameter int DISCH_TIMEOUT = `DISCH_TIMEOUT_CYC
) (
    input  wire logic       clk,                          // System clock
    input  wire logic       arst_n,                       // Async reset, active low
    input  wire logic       clk_en,                       // Freezes all state when low
    input  wire logic       wr_en,                        // Register write strobe
    input  wire logic [7:0] addr,                         // Register address
    input  wire logic [7:0] wdata,                        // Write data
    output logic      [7:0] rdata,                        // Read data, registered
    input  wire logic       plug_flip_select,             // Orientation bit
    input  wire logic [1:0] first_term,                   // First pin termination setting
    input  wire logic [1:0] second_term,                  // Second pin termination setting
    input  wire logic       toggling,                     // Role toggling active
    input  wire logic       role_is_pulldown,             // Resolved role
    input  wire logic       is_source,                    // Device acting as source
    input  wire logic       disconnect_pin,               // Disconnect comparator, async
    input  wire logic       below_safe0v_pin,             // Safe zero-volt comparator, async
    input  wire logic [1:0] first_sense,                  // First pin comparator code
    input  wire logic [1:0] second_sense,                 // Second pin comparator code
    output logic            discharge_timer_off,          // Timer stopped
    output logic            cable_power_overcurrent_off,  // Overcurrent protection off
    output logic            bus_voltage_monitor_off,      // Monitor off, results read zero
    output logic            voltage_alarm_off,            // Alarm reporting off
    output logic            bleed_load_enable,            // Low-current load
    output logic            bus_discharge,                // Bus discharge control
    output logic            bus_source_allow,             // Sourcing permitted
    output logic            cable_power_first,            // Cable power on first pin
    output logic            cable_power_second,           // Cable power on second pin
    output logic            auto_discharge_failed,        // Timeout pulse
    output logic            cc_status_alert               // Status change pulse
);
    logic [7:0] fault_ctrl_ff;
    logic [7:0] power_ctrl_ff;
    logic [7:0] cc_stat_ff;
    logic [7:0] nxt_cc_stat;
    logic [1:0] disc_sync_ff;
    logic [1:0] safe_sync_ff;
    logic       disc_prev_ff;
    disch_e     disch_ff;
    logic       disch_auto_ff;
    logic [31:0] timer_ff;
    logic [1:0] first_stat;
    logic [1:0] second_stat;
    logic       blank_first;
    logic       blank_second;
    logic       disc_edge;

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction

    // Writes land only on writable bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_ctrl_ff <= `FAULT_CONTROL_RESET;
            power_ctrl_ff <= `POWER_CONTROL_RESET;
        end else if (clk_en && wr_en) begin
            // RULE23 - reserved bits masked
            if (wr_hit(addr, `FAULT_CONTROL_ADDR)) begin
                fault_ctrl_ff <= wdata & `FAULT_CONTROL_MASK;
            end
            // RULE11 - capability bit stored only
            if (wr_hit(addr, `POWER_CONTROL_ADDR)) begin
                power_ctrl_ff <= wdata & `POWER_CONTROL_MASK;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            case (addr)
                `FAULT_CONTROL_ADDR:     rdata <= fault_ctrl_ff;
                `POWER_CONTROL_ADDR:     rdata <= power_ctrl_ff;
                `CONNECTION_STATUS_ADDR: rdata <= cc_stat_ff;
                default:                 rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            disc_sync_ff <= 2'h0;
            safe_sync_ff <= 2'h0;
            disc_prev_ff <= 1'b0;
        end else if (clk_en) begin
            disc_sync_ff <= {disc_sync_ff[0], disconnect_pin};
            safe_sync_ff <= {safe_sync_ff[0], below_safe0v_pin};
            disc_prev_ff <= disc_sync_ff[1];
        end
    end

    assign disc_edge = disc_sync_ff[1] && !disc_prev_ff;

    // Discharge sequencer; source first drops sourcing, then discharges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            disch_ff      <= DS_IDLE;
            disch_auto_ff <= 1'b0;
        end else if (clk_en) begin
            case (disch_ff)
                DS_IDLE: begin
                    // RULE10 - forced discharge start
                    if (power_ctrl_ff[`PC_FORCED_DISCHARGE_BIT]) begin
                        disch_ff      <= DS_ACTIVE;
                        disch_auto_ff <= 1'b0;
                    // RULE5 - source stops sourcing first
                    end else if (disc_edge && power_ctrl_ff[`PC_AUTO_DISCHARGE_ON_DISCONNECT_BIT] && is_source) begin
                        disch_ff      <= DS_STOP;
                        disch_auto_ff <= 1'b1;
                    // RULE6 - sink discharges only
                    end else if (disc_edge && power_ctrl_ff[`PC_AUTO_DISCHARGE_ON_DISCONNECT_BIT]) begin
                        disch_ff      <= DS_ACTIVE;
                        disch_auto_ff <= 1'b1;
                    end
                end
                DS_STOP: disch_ff <= DS_ACTIVE;
                DS_ACTIVE: begin
                    // RULE8 - end below safe voltage
                    if (safe_sync_ff[1]) begin
                        disch_ff <= DS_IDLE;
                    // RULE10 - forced release
                    end else if (!disch_auto_ff && !power_ctrl_ff[`PC_FORCED_DISCHARGE_BIT]) begin
                        disch_ff <= DS_IDLE;
                    end
                end
                default: disch_ff <= DS_IDLE;
            endcase
        end
    end

    // Timeout counter; only auto discharges flag a failure
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_ff              <= 32'h0;
            auto_discharge_failed <= 1'b0;
        end else if (clk_en) begin
            auto_discharge_failed <= 1'b0;
            // RULE1 - timer off clears count
            if (disch_ff == DS_IDLE || fault_ctrl_ff[`FC_TIMER_OFF_BIT]) begin
                timer_ff <= 32'h0;
            end else if (timer_ff == 32'(DISCH_TIMEOUT - 1)) begin
                timer_ff <= timer_ff;
            end else begin
                timer_ff <= timer_ff + 32'h1;
                // RULE22 - failure on timeout
                if (timer_ff == 32'(DISCH_TIMEOUT - 2) && disch_auto_ff) begin
                    auto_discharge_failed <= 1'b1;
                end
            end
        end
    end

    // Outputs registered from control state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            discharge_timer_off         <= 1'b0;
            cable_power_overcurrent_off <= 1'b0;
            bus_voltage_monitor_off     <= 1'b1;
            voltage_alarm_off           <= 1'b1;
            bleed_load_enable           <= 1'b0;
            bus_discharge               <= 1'b0;
            bus_source_allow            <= 1'b0;
            cable_power_first           <= 1'b0;
            cable_power_second          <= 1'b0;
        end else if (clk_en) begin
            // RULE1 - timer off output
            discharge_timer_off         <= fault_ctrl_ff[`FC_TIMER_OFF_BIT];
            // RULE2 - overcurrent off
            cable_power_overcurrent_off <= fault_ctrl_ff[`FC_OCP_OFF_BIT];
            // RULE3 - monitor off
            bus_voltage_monitor_off     <= power_ctrl_ff[`PC_MON_OFF_BIT];
            // RULE4 - alarm off
            voltage_alarm_off           <= power_ctrl_ff[`PC_ALARM_OFF_BIT];
            // RULE9 - bleed load
            bleed_load_enable           <= power_ctrl_ff[`PC_BLEED_BIT];
            bus_discharge               <= disch_ff == DS_ACTIVE;
            // RULE7 - sourcing dropped before discharge
            bus_source_allow            <= disch_ff == DS_IDLE && !(disc_edge && power_ctrl_ff[`PC_AUTO_DISCHARGE_ON_DISCONNECT_BIT])
                                           && !power_ctrl_ff[`PC_FORCED_DISCHARGE_BIT];
            // RULE20 - orientation steering
            // RULE12 - cable power enable
            cable_power_first           <= power_ctrl_ff[`PC_CABLE_PWR_BIT] && plug_flip_select;
            cable_power_second          <= power_ctrl_ff[`PC_CABLE_PWR_BIT] && !plug_flip_select;
        end
    end

    // RULE18 - both pins blanked while searching or with cable power on and orientation bit low
    assign blank_first  = toggling || (power_ctrl_ff[`PC_CABLE_PWR_BIT] && !plug_flip_select);
    assign blank_second = blank_first;

    pin_status_if first_if ();
    pin_status_if second_if ();
    // RULE21 - termination encoding used
    assign first_if.term   = first_term;
    assign first_if.sense  = first_sense;
    assign first_if.role   = role_is_pulldown;
    assign first_if.blank  = blank_first;
    assign second_if.term  = second_term;
    assign second_if.sense = second_sense;
    assign second_if.role  = role_is_pulldown;
    assign second_if.blank = blank_second;
    assign first_stat      = first_if.status;
    assign second_stat     = second_if.status;

    pin_status_calc u_first (
        .p (first_if.calc)
    );
    pin_status_calc u_second (
        .p (second_if.calc)
    );

    // RULE13 - searching bit
    // RULE14 - resolved role bit
    assign nxt_cc_stat = {2'h0, toggling, role_is_pulldown, second_stat, first_stat};

    // Status register and change alert
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cc_stat_ff      <= `CONNECTION_STATUS_RESET;
            cc_status_alert <= 1'b0;
        end else if (clk_en) begin
            cc_stat_ff      <= nxt_cc_stat;
            // RULE19 - change raises alert
            cc_status_alert <= nxt_cc_stat != cc_stat_ff;
        end
    end

    a_source_before_disch: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        bus_discharge |-> !bus_source_allow) else $error("sourcing outlasted discharge");
    a_source_auto_seq: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        (clk_en && disch_ff == DS_IDLE && disc_edge && power_ctrl_ff[`PC_AUTO_DISCHARGE_ON_DISCONNECT_BIT] && is_source
         && !power_ctrl_ff[`PC_FORCED_DISCHARGE_BIT]) |=> disch_ff == DS_STOP) else $error("source sequence wrong");
    a_sink_auto_seq: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        (clk_en && disch_ff == DS_IDLE && disc_edge && power_ctrl_ff[`PC_AUTO_DISCHARGE_ON_DISCONNECT_BIT] && !is_source
         && !power_ctrl_ff[`PC_FORCED_DISCHARGE_BIT]) |=> disch_ff == DS_ACTIVE) else $error("sink sequence wrong");
    a_disch_safe_end: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
        (clk_en && disch_ff == DS_ACTIVE && safe_sync_ff[1]) |=> disch_ff == DS_IDLE)
        else $error("discharge not ended");
    a_force_start: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
        (clk_en && disch_ff == DS_IDLE && power_ctrl_ff[`PC_FORCED_DISCHARGE_BIT]) |=> disch_ff == DS_ACTIVE)
        else $error("forced discharge missing");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n) // RULE23
        (fault_ctrl_ff[7:4] == 4'h0) && (fault_ctrl_ff[2:1] == 2'h0) && !power_ctrl_ff[7]
        && cc_stat_ff[7:6] == 2'h0)
        else $error("reserved bits set");
    a_status_alert: assert property (@(posedge clk) disable iff (!arst_n) // RULE19
        (clk_en && nxt_cc_stat != cc_stat_ff) |=> cc_status_alert) else $error("alert missing");
    a_blank_status: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
        toggling |-> nxt_cc_stat[3:0] == 4'h0) else $error("status not blanked");
    a_timer_frozen: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
        (clk_en && fault_ctrl_ff[`FC_TIMER_OFF_BIT]) |=> timer_ff == 32'h0) else $error("timer ran");
    a_orient_steer: assert property (@(posedge clk) disable iff (!arst_n) // RULE20
        (clk_en && power_ctrl_ff[`PC_CABLE_PWR_BIT]) |=> (cable_power_first == $past(plug_flip_select)))
        else $error("orientation wrong");
    a_fail_on_timeout: assert property (@(posedge clk) disable iff (!arst_n) // RULE22
        (clk_en && disch_auto_ff && disch_ff != DS_IDLE && !fault_ctrl_ff[`FC_TIMER_OFF_BIT]
         && timer_ff == 32'(DISCH_TIMEOUT - 2)) |=> auto_discharge_failed) else $error("failure flag missing");
    a_cable_power_off: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
        (clk_en && !power_ctrl_ff[`PC_CABLE_PWR_BIT]) |=> !cable_power_first && !cable_power_second)
        else $error("cable power not off");
    a_monitor_follow: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
        clk_en |=> bus_voltage_monitor_off == $past(power_ctrl_ff[`PC_MON_OFF_BIT]))
        else $error("monitor control wrong");
    a_alarm_follow: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        clk_en |=> voltage_alarm_off == $past(power_ctrl_ff[`PC_ALARM_OFF_BIT]))
        else $error("alarm control wrong");
    a_bleed_follow: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
        clk_en |=> bleed_load_enable == $past(power_ctrl_ff[`PC_BLEED_BIT]))
        else $error("bleed control wrong");
    a_overcurrent_follow: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        clk_en |=> cable_power_overcurrent_off == $past(fault_ctrl_ff[`FC_OCP_OFF_BIT]))
        else $error("overcurrent control wrong");
    c_source_disch: cover property (@(posedge clk) disch_ff == DS_STOP ##1 disch_ff == DS_ACTIVE);
    c_safe_end: cover property (@(posedge clk) disch_ff == DS_ACTIVE ##1 disch_ff == DS_IDLE);
    c_alert: cover property (@(posedge clk) cc_status_alert);
    c_forced_disch: cover property (@(posedge clk) power_ctrl_ff[`PC_FORCED_DISCHARGE_BIT] && bus_discharge);
    c_auto_fail: cover property (@(posedge clk) auto_discharge_failed);
endmodule

// *** verification/port_manager_host.sv ***
`timescale 1ns/1ps
module port_manager_host (
    input  wire logic       clk,   // Register bus clock
    output logic            wr_en, // Write strobe
    output logic      [7:0] addr,  // Register address
    output logic      [7:0] wdata, // Write data
    input  wire logic [7:0] rdata  // Registered read data
);
    initial begin
        wr_en = 1'b0;
        addr  = 8'hFF;
        wdata = 8'h00;
    end

    // Released lines carry the inverse so a stale value never passes as valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask

    // Read data is taken mid-cycle, well away from the edge that loads it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        @(negedge clk);
        d = rdata;
        @(posedge clk);
        addr <= ~a;
    endtask
endmodule

// *** verification/test_power_fault_cc_status_regs.sv ***
`timescale 1ns/1ps
module test_power_fault_cc_status_regs
    import pwr_cc_pkg::*;
;
    logic        clk, arst_n, wr_en, flip, tog, role, src, disc, below, cp, ovl, en;
    logic        toff, ocp, mon, alarm, bleed, dis, src_ok, cpf, cps, fail, alert;
    logic [7:0]  addr, wdata, rdata, d, d1, r8, prev, mid, e;
    logic [1:0]  t1, t2, s1, s2;
    logic [31:0] r;
    int          miscompares, tests_run, nalert, nfail, cyc, n0, seed;

    port_manager_host i_host (.clk(clk), .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata));

    // Short timeout keeps the failure case inside a few dozen cycles
    power_fault_cc_status_regs #(.DISCH_TIMEOUT(20)) i_dut (
        .clk(clk), .arst_n(arst_n), .clk_en(en), .wr_en(wr_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .plug_flip_select(flip), .first_term(t1), .second_term(t2),
        .toggling(tog), .role_is_pulldown(role), .is_source(src), .disconnect_pin(disc),
        .below_safe0v_pin(below), .first_sense(s1), .second_sense(s2), .discharge_timer_off(toff),
        .cable_power_overcurrent_off(ocp), .bus_voltage_monitor_off(mon), .voltage_alarm_off(alarm),
        .bleed_load_enable(bleed), .bus_discharge(dis), .bus_source_allow(src_ok),
        .cable_power_first(cpf), .cable_power_second(cps), .auto_discharge_failed(fail),
        .cc_status_alert(alert));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) nalert <= nalert + int'(alert === 1'b1);
    always @(posedge clk) nfail <= nfail + int'(fail === 1'b1);
    always @(posedge clk) if (dis === 1'b1 && src_ok === 1'b1) ovl <= 1'b1;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic summarize();
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic wait_dis(input logic v);
        int k;
        k = 0;
        while (dis !== v && k < 40) begin
            @(negedge clk);
            k++;
        end
        chk({7'h0, dis}, {7'h0, v});
    endtask

    function automatic logic [1:0] fld(input logic [1:0] t, input logic [1:0] s);
        if (tog || (cp && !flip) || t == TERM_RA || t == TERM_OPEN)
            return 2'h0;
        // Reserved code on the pull-up side is not reported
        if (!role && s == 2'h3)
            return 2'h0;
        return s;
    endfunction

    function automatic logic [7:0] stat();
        return {2'h0, tog, role, fld(t2, s2), fld(t1, s1)};
    endfunction

    function automatic logic [1:0] term(input logic [1:0] c, input logic rl);
        if (c == 2'h0 || c == 2'h3)
            return c;
        return rl ? TERM_PULLDN : TERM_PULLUP;
    endfunction

    initial begin
        seed = 32'hf027;
        {miscompares, tests_run, nalert, nfail, cyc} = '0;
        {arst_n, flip, tog, role, src, disc, below, cp, ovl} = '0;
        {s1, s2} = '0;
        en = 1'b1;
        t1 = TERM_OPEN;
        t2 = TERM_OPEN;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        i_host.rd(8'h1B, r8);
        chk(r8, 8'h00);
        i_host.rd(8'h1C, r8);
        chk(r8, 8'h60);
        chk({6'h0, mon, alarm}, 8'h03);
        i_host.rd(8'h1D, r8);
        chk(r8, 8'h00);
        i_host.rd(8'h40, r8);
        chk(r8, 8'h00);
        prev = 8'h00;
        for (int i = 0; i < 40; i++) begin
            n0 = nalert;
            d = 8'($random(seed)) & 8'hEB;
            d1 = 8'($random(seed));
            r = $random(seed);
            if (i == 0) begin
                d[0] = 1'b1;
                r[5:0] = 6'h05;
            end
            i_host.wr(8'h1B, d1);
            i_host.wr(8'h1C, d);
            cp = d[0];
            mid = stat();
            i_host.rd(8'h1B, r8);
            chk(r8, d1 & 8'h09);
            i_host.rd(8'h1C, r8);
            chk(r8, d & 8'h7F);
            chk({3'h0, toff, ocp, mon, alarm, bleed}, {3'h0, d1[3], d1[0], d[6], d[5], d[3]});
            @(posedge clk);
            role <= r[2];
            tog <= r[3] & r[4];
            flip <= r[5];
            s1 <= r[7:6];
            s2 <= r[9:8];
            // All pin inputs move on one edge, so the step raises at most one alert
            t1 <= term(r[1:0], r[2]);
            t2 <= term(r[11:10], r[2]);
            repeat (5) @(posedge clk);
            e = stat();
            i_host.rd(8'h1D, r8);
            chk(r8, e);
            chk({6'h0, cpf, cps}, {6'h0, cp & flip, cp & !flip});
            chk(8'(nalert - n0), 8'(int'(mid != prev) + int'(e != mid)));
            prev = e;
        end
        i_host.wr(8'h1D, 8'hFF);
        i_host.rd(8'h1D, r8);
        chk(r8, e);
        i_host.wr(8'h1B, 8'h00);
        src <= 1'b1;
        i_host.wr(8'h1C, 8'h04);
        wait_dis(1'b1);
        chk({7'h0, src_ok}, 8'h00);
        @(posedge clk);
        below <= 1'b1;
        wait_dis(1'b0);
        i_host.wr(8'h1C, 8'h10);
        below <= 1'b0;
        repeat (8) @(posedge clk);
        disc <= 1'b1;
        wait_dis(1'b1);
        chk({7'h0, src_ok}, 8'h00);
        @(posedge clk);
        below <= 1'b1;
        wait_dis(1'b0);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            {disc, below, src} <= 3'b000;
            i_host.wr(8'h1B, {4'h0, j[0], 3'h0});
            repeat (8) @(posedge clk);
            n0 = nfail;
            disc <= 1'b1;
            wait_dis(1'b1);
            repeat (40) @(posedge clk);
            chk(8'(nfail - n0), {7'h0, ~j[0]});
            below <= 1'b1;
            repeat (10) @(posedge clk);
        end
        // A write while the enable is low must not land
        @(posedge clk);
        en <= 1'b0;
        i_host.wr(8'h1B, 8'h01);
        en <= 1'b1;
        i_host.rd(8'h1B, r8);
        chk(r8, 8'h08);
        chk({7'h0, ocp}, 8'h00);
        chk({7'h0, ovl}, 8'h00);
        summarize();
    end
endmodule
